// ===== flash_spi_front_end.sv
// Serial interface front end of a serial NOR flash: decode, shift, busy.
// Assumes the array sits outside on i_mclk and answers i_arr_data for
// o_arr_addr within one cycle; the link clock is sampled, not used.
`include "flash_fe_consts.svh"
`default_nettype none

module flash_spi_front_end #(
	parameter int unsigned PROG_CYCLES   = `PROG_TIME_US * `MCLK_MHZ,
	parameter int unsigned SECTOR_CYCLES = `SECTOR_TIME_US * `MCLK_MHZ,
	parameter int unsigned BLOCK_CYCLES  = `BLOCK_TIME_US * `MCLK_MHZ,
	parameter int unsigned CHIP_CYCLES   = `CHIP_TIME_US * `MCLK_MHZ,
	parameter logic [7:0]  MFR_CODE      = 8'h5A, // Arbitrary value
	parameter logic [7:0]  DEV_CODE      = 8'h13, // Arbitrary value
	parameter logic [7:0]  MEM_TYPE      = 8'h40, // Arbitrary value
	parameter logic [7:0]  CAP_CODE      = 8'h14, // Arbitrary value
	parameter logic [63:0] UNIQUE_ID     = 64'h0123_4567_89AB_CDEF // Arbitrary
) (
	input  wire logic                      i_mclk,
	input  wire logic                      i_rst,
	input  wire logic                      i_sclk,
	input  wire logic                      i_select_n,
	input  wire logic                      i_bidir_lane_low,
	input  wire logic                      i_protect_n,
	input  wire logic [7:0]                i_arr_data,
	output logic                           o_bidir_lane_low,
	output logic                           o_bidir_lane_low_oe,
	output logic                           o_out_lane_high,
	output logic                           o_out_lane_high_oe,
	output logic [23:0]                    o_arr_addr,
	output logic                           o_prog_strobe,
	output logic [7:0]                     o_prog_data,
	output logic                           o_erase_strobe,
	output flash_fe_pkg::erase_kind_t      o_erase_kind,
	output logic                           o_busy,
	output logic                           o_write_latch_flag,
	output logic                           o_deep_sleep
);

	logic [3:0]               sync_q;
	logic                     cs_q;
	logic                     sclk_q;
	logic                     din_q;
	logic                     wp_q;
	logic                     cs_d;
	logic                     sclk_d;
	logic                     sclk_rise;
	logic                     sclk_fall;
	logic                     cs_fall;
	logic                     cs_rise;
	logic                     active;
	logic [5:0]               cnt;
	logic [2:0]               bitpos;
	logic [7:0]               sr;
	logic [7:0]               next_byte;
	flash_fe_pkg::cmd_t       cmd;
	flash_fe_pkg::cmd_t       next_cmd;
	logic                     prog_any;
	logic [7:0]               osh;
	logic [2:0]               obit;
	logic [2:0]               byte_idx;
	logic [2:0]               next_idx;
	logic [7:0]               src_byte;
	logic [5:0]               hdr;
	logic                     dual;
	logic                     is_array;
	logic                     out_go;
	logic                     out_load;
	logic                     status_guard_bit;
	logic [2:0]               bp;
	logic [`BUSY_W-1:0]       busy_cnt;
	logic [7:0]               status;

	// ======================================================================
	// Pin sampling; link clock is sampled, so edges cost two cycles delay
	pin_sync #(
		.W (4)
	) u_pin_sync (
		.i_mclk (i_mclk),
		.i_rst  (i_rst),
		.i_d    ({i_select_n, i_sclk, i_bidir_lane_low, i_protect_n}),
		.o_q    (sync_q)
	);
	assign {cs_q, sclk_q, din_q, wp_q} = sync_q;

	// Edge history; select resets low so a fall needs a prior high
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cs_d   <= 1'b0;
			sclk_d <= 1'b0;
		end else begin
			cs_d   <= cs_q;
			sclk_d <= sclk_q;
		end
	end

	assign sclk_rise = sclk_q & ~sclk_d;
	assign sclk_fall = ~sclk_q & sclk_d;
	assign cs_fall   = cs_d & ~cs_q;
	assign cs_rise   = cs_q & ~cs_d;
	assign next_byte = {sr[6:0], din_q};
	assign status    = {status_guard_bit, 2'b00, bp, o_write_latch_flag,
		o_busy};
	assign dual      = cmd == flash_fe_pkg::dual_read_cmd;
	assign is_array  = cmd inside {flash_fe_pkg::read_cmd,
		flash_fe_pkg::fast_read_cmd, flash_fe_pkg::dual_read_cmd};

	// ======================================================================
	// Opcode decode with sleep, busy and latch gating
	always_comb begin
		case (next_byte)
			`OP_STATUS_READ:   next_cmd = flash_fe_pkg::status_read_cmd;
			`OP_LATCH_SET:     next_cmd = flash_fe_pkg::latch_set_cmd;
			`OP_LATCH_CLR:     next_cmd = flash_fe_pkg::latch_clr_cmd;
			`OP_STATUS_WRITE:  next_cmd = flash_fe_pkg::status_write_cmd;
			`OP_PAGE_PROGRAM:  next_cmd = flash_fe_pkg::page_program_cmd;
			`OP_SECTOR_ERASE:  next_cmd = flash_fe_pkg::sector_erase_cmd;
			`OP_BLOCK32_ERASE: next_cmd = flash_fe_pkg::block32_erase_cmd;
			`OP_BLOCK64_ERASE: next_cmd = flash_fe_pkg::block64_erase_cmd;
			`OP_CHIP_ERASE_A,
			`OP_CHIP_ERASE_B:  next_cmd = flash_fe_pkg::chip_erase_cmd;
			`OP_READ:          next_cmd = flash_fe_pkg::read_cmd;
			`OP_FAST_READ:     next_cmd = flash_fe_pkg::fast_read_cmd;
			`OP_DUAL_READ:     next_cmd = flash_fe_pkg::dual_read_cmd;
			`OP_DEEP_SLEEP:    next_cmd = flash_fe_pkg::deep_sleep_cmd;
			`OP_WAKE_ID:       next_cmd = flash_fe_pkg::wake_id_cmd;
			`OP_MFR_ID:        next_cmd = flash_fe_pkg::mfr_id_cmd;
			`OP_IDENT:   next_cmd = flash_fe_pkg::read_identification_cmd;
			`OP_UNIQUE_ID:     next_cmd = flash_fe_pkg::unique_id_cmd;
			default:           next_cmd = flash_fe_pkg::unknown_cmd;
		endcase
		// Sleep accepts only wake; busy accepts only status polling
		if (o_deep_sleep && next_cmd != flash_fe_pkg::wake_id_cmd)
			next_cmd = flash_fe_pkg::unknown_cmd;
		else if (o_busy && next_cmd != flash_fe_pkg::status_read_cmd)
			next_cmd = flash_fe_pkg::unknown_cmd;
		else if (!o_write_latch_flag && next_cmd inside {
			flash_fe_pkg::status_write_cmd, flash_fe_pkg::page_program_cmd,
			flash_fe_pkg::sector_erase_cmd, flash_fe_pkg::block32_erase_cmd,
			flash_fe_pkg::block64_erase_cmd, flash_fe_pkg::chip_erase_cmd})
			next_cmd = flash_fe_pkg::unknown_cmd;
	end

	// Bits in before first output bit; non-output commands never start
	always_comb begin
		case (cmd)
			flash_fe_pkg::status_read_cmd,
			flash_fe_pkg::read_identification_cmd: hdr = `HDR_SHORT;
			flash_fe_pkg::read_cmd,
			flash_fe_pkg::wake_id_cmd,
			flash_fe_pkg::mfr_id_cmd:              hdr = `HDR_ADDR;
			flash_fe_pkg::fast_read_cmd,
			flash_fe_pkg::dual_read_cmd,
			flash_fe_pkg::unique_id_cmd:           hdr = `HDR_DUMMY;
			default:                               hdr = `HDR_NEVER;
		endcase
	end

	// ======================================================================
	// Input shifting and frame bookkeeping
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			active <= 1'b0;
			cnt    <= 6'h00;
			bitpos <= 3'h0;
			sr     <= 8'h00;
			cmd    <= flash_fe_pkg::no_cmd;
		end else if (cs_fall) begin
			active <= 1'b1;
			cnt    <= 6'h00;
			bitpos <= 3'h0;
			cmd    <= flash_fe_pkg::no_cmd;
		end else if (cs_q) begin
			active <= 1'b0;
		end else if (active && sclk_rise) begin
			sr     <= next_byte;
			bitpos <= bitpos + 3'h1;
			if (cnt != `CNT_MAX)
				cnt <= cnt + 6'h01;
			if (cnt == `CNT_OPCODE_LAST)
				cmd <= next_cmd;
		end
	end

	// Program data bytes stream to the array as they complete
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_prog_strobe <= 1'b0;
			o_prog_data   <= 8'h00;
			prog_any      <= 1'b0;
		end else begin
			o_prog_strobe <= 1'b0;
			if (cs_fall) begin
				prog_any <= 1'b0;
			end else if (active && !cs_q && sclk_rise && bitpos == 3'h7 &&
				cmd == flash_fe_pkg::page_program_cmd &&
				cnt >= `CNT_DATA_LAST) begin
				o_prog_strobe <= 1'b1;
				o_prog_data   <= next_byte;
				prog_any      <= 1'b1;
			end
		end
	end

	// Address: three bytes in, then page wrap or linear read increment
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_arr_addr <= 24'h000000;
		end else if (active && !cs_q && sclk_rise) begin
			case (cnt)
				`CNT_ADDR_HI:  o_arr_addr[23:16] <= next_byte;
				`CNT_ADDR_MID: o_arr_addr[15:8]  <= next_byte;
				`CNT_ADDR_LO:  o_arr_addr[7:0]   <= next_byte;
				default:       o_arr_addr        <= o_arr_addr;
			endcase
		end else if (o_prog_strobe) begin
			o_arr_addr[7:0] <= o_arr_addr[7:0] + 8'h01;
		end else if (out_load && is_array) begin
			o_arr_addr <= o_arr_addr + 24'h000001;
		end
	end

	// ======================================================================
	// Output byte source and sequence index
	always_comb begin
		next_idx = byte_idx + 3'h1;
		case (cmd)
			flash_fe_pkg::status_read_cmd: src_byte = status;
			flash_fe_pkg::read_cmd,
			flash_fe_pkg::fast_read_cmd,
			flash_fe_pkg::dual_read_cmd:   src_byte = i_arr_data;
			flash_fe_pkg::wake_id_cmd:     src_byte = DEV_CODE;
			flash_fe_pkg::mfr_id_cmd:      src_byte =
				(byte_idx[0] ^ o_arr_addr[0]) ? DEV_CODE : MFR_CODE;
			flash_fe_pkg::read_identification_cmd: begin
				src_byte = (byte_idx == 3'h0) ? MFR_CODE :
					(byte_idx == 3'h1) ? MEM_TYPE : CAP_CODE;
				if (byte_idx == 3'h2)
					next_idx = 3'h0;
			end
			flash_fe_pkg::unique_id_cmd:
				src_byte = UNIQUE_ID[{~byte_idx, 3'b000} +: 8];
			default:                       src_byte = 8'h00;
		endcase
	end

	assign out_go   = active && !cs_q && sclk_fall && cnt >= hdr;
	assign out_load = out_go && obit == 3'h0;

	// Output shifter; lanes change only on link falling edges
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_out_lane_high     <= 1'b0;
			o_out_lane_high_oe  <= 1'b0;
			o_bidir_lane_low    <= 1'b0;
			o_bidir_lane_low_oe <= 1'b0;
			osh                 <= 8'h00;
			obit                <= 3'h0;
			byte_idx            <= 3'h0;
		end else if (cs_q) begin
			o_out_lane_high_oe  <= 1'b0;
			o_bidir_lane_low_oe <= 1'b0;
			obit                <= 3'h0;
			byte_idx            <= 3'h0;
		end else if (out_go) begin
			o_out_lane_high_oe  <= 1'b1;
			o_bidir_lane_low_oe <= dual;
			if (obit == 3'h0) begin
				o_out_lane_high  <= src_byte[7];
				o_bidir_lane_low <= src_byte[6];
				osh      <= dual ? {src_byte[5:0], 2'b00} :
					{src_byte[6:0], 1'b0};
				obit     <= dual ? 3'h3 : 3'h7;
				byte_idx <= next_idx;
			end else begin
				o_out_lane_high  <= osh[7];
				o_bidir_lane_low <= osh[6];
				osh  <= dual ? {osh[5:0], 2'b00} : {osh[6:0], 1'b0};
				obit <= obit - 3'h1;
			end
		end
	end

	// ======================================================================
	// Status, write latch, sleep and busy timer; commands act on select rise
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			busy_cnt           <= '0;
			o_busy             <= 1'b0;
			o_write_latch_flag <= 1'b0;
			status_guard_bit   <= `SR_GUARD_RESET;
			bp                 <= `SR_BP_RESET;
			o_deep_sleep       <= 1'b0;
			o_erase_strobe     <= 1'b0;
			o_erase_kind       <= flash_fe_pkg::erase_sector;
		end else begin
			o_erase_strobe <= 1'b0;
			if (o_busy) begin
				busy_cnt <= busy_cnt - `BUSY_W'(1);
				if (busy_cnt == `BUSY_W'(1)) begin
					o_busy             <= 1'b0;
					o_write_latch_flag <= 1'b0;
				end
			end
			if (cs_rise && active) begin
				case (cmd)
					flash_fe_pkg::latch_set_cmd:
						if (cnt == `CNT_OPCODE_ONLY)
							o_write_latch_flag <= 1'b1;
					flash_fe_pkg::latch_clr_cmd:
						if (cnt == `CNT_OPCODE_ONLY)
							o_write_latch_flag <= 1'b0;
					flash_fe_pkg::status_write_cmd:
						// Guard bit plus low protect pin refuses the write
						if (cnt == `CNT_STATUS_FRAME &&
							!(status_guard_bit && !wp_q)) begin
							status_guard_bit   <= sr[`SR_GUARD_POS];
							bp                 <= sr[`SR_BP_HI:`SR_BP_LO];
							o_write_latch_flag <= 1'b0;
						end
					flash_fe_pkg::page_program_cmd:
						if (prog_any) begin
							o_busy   <= 1'b1;
							busy_cnt <= `BUSY_W'(PROG_CYCLES);
						end
					flash_fe_pkg::sector_erase_cmd,
					flash_fe_pkg::block32_erase_cmd,
					flash_fe_pkg::block64_erase_cmd:
						if (cnt == `CNT_ADDR_FRAME) begin
							o_erase_strobe <= 1'b1;
							o_busy         <= 1'b1;
							if (cmd == flash_fe_pkg::sector_erase_cmd) begin
								o_erase_kind <= flash_fe_pkg::erase_sector;
								busy_cnt <= `BUSY_W'(SECTOR_CYCLES);
							end else begin
								o_erase_kind <=
									(cmd == flash_fe_pkg::block32_erase_cmd) ?
									flash_fe_pkg::erase_block32 :
									flash_fe_pkg::erase_block64;
								busy_cnt <= `BUSY_W'(BLOCK_CYCLES);
							end
						end
					flash_fe_pkg::chip_erase_cmd:
						if (cnt == `CNT_OPCODE_ONLY) begin
							o_erase_strobe <= 1'b1;
							o_erase_kind   <= flash_fe_pkg::erase_chip;
							o_busy         <= 1'b1;
							busy_cnt       <= `BUSY_W'(CHIP_CYCLES);
						end
					flash_fe_pkg::deep_sleep_cmd:
						if (cnt == `CNT_OPCODE_ONLY)
							o_deep_sleep <= 1'b1;
					flash_fe_pkg::wake_id_cmd:
						o_deep_sleep <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	// ======================================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	chk_hiz_deselect: assert property (cs_q |=>
		!o_out_lane_high_oe && !o_bidir_lane_low_oe)
		else $error("lanes driven while deselected");
	chk_capture_rise: assert property (
		active && !cs_q && !cs_fall && sclk_rise |=> sr == $past(next_byte))
		else $error("input bit not captured on rising edge");
	chk_out_fall: assert property (!sclk_fall |=>
		$stable(o_out_lane_high) && $stable(o_bidir_lane_low))
		else $error("output changed away from falling edge");
	chk_dual_only: assert property (
		o_bidir_lane_low_oe |-> cmd == flash_fe_pkg::dual_read_cmd)
		else $error("lane low driven outside dual read");
	chk_latch_cause: assert property ($rose(o_write_latch_flag) |->
		cmd == flash_fe_pkg::latch_set_cmd && $past(cs_rise))
		else $error("write latch set by other command");
	chk_latch_done: assert property (
		$fell(o_busy) |-> !o_write_latch_flag)
		else $error("write latch kept after operation");
	chk_erase_busy: assert property (
		o_erase_strobe |-> o_busy ##1 o_busy)
		else $error("erase without busy");
	chk_page_wrap: assert property (o_prog_strobe |=>
		o_arr_addr[23:8] == $past(o_arr_addr[23:8]) &&
		o_arr_addr[7:0] == $past(o_arr_addr[7:0]) + 8'h01)
		else $error("program address left the page");
	chk_unknown_quiet: assert property (
		cmd == flash_fe_pkg::unknown_cmd |-> !o_out_lane_high_oe)
		else $error("unknown opcode drove output");
	chk_read_step: assert property (
		out_load && cmd == flash_fe_pkg::read_cmd |=>
		o_arr_addr == $past(o_arr_addr) + 24'h000001)
		else $error("read address did not advance");
	chk_prog_time: assert property ($rose(o_busy) &&
		cmd == flash_fe_pkg::page_program_cmd |->
		busy_cnt == `BUSY_W'(PROG_CYCLES))
		else $error("wrong program busy time");

endmodule // flash_spi_front_end

`default_nettype wire

// ===== flash_fe_consts.svh
// Opcodes, frame bit counts, status layout and timing for the serial
// flash front end.
// Assumes a 25 MHz system clock and a host using SPI mode 0 or mode 3.
`ifndef FLASH_FE_CONSTS_SVH
`define FLASH_FE_CONSTS_SVH

// ==========================================================================
// Opcodes
`define OP_STATUS_READ    8'h05
`define OP_LATCH_SET      8'h06
`define OP_LATCH_CLR      8'h04
`define OP_STATUS_WRITE   8'h01
`define OP_PAGE_PROGRAM   8'h02
`define OP_SECTOR_ERASE   8'h20
`define OP_BLOCK32_ERASE  8'h52
`define OP_BLOCK64_ERASE  8'hD8
`define OP_CHIP_ERASE_A   8'hC7
`define OP_CHIP_ERASE_B   8'h60
`define OP_READ           8'h03
`define OP_FAST_READ      8'h0B
`define OP_DUAL_READ      8'h3B
`define OP_DEEP_SLEEP     8'hB9
`define OP_WAKE_ID        8'hAB
`define OP_MFR_ID         8'h90
`define OP_IDENT          8'h9F
`define OP_UNIQUE_ID      8'h4B

// ==========================================================================
// Rising-edge counts within a frame (count before the edge)
`define CNT_OPCODE_LAST   6'h07
`define CNT_ADDR_HI       6'h0F
`define CNT_ADDR_MID      6'h17
`define CNT_ADDR_LO       6'h1F
`define CNT_DATA_LAST     6'h27
`define CNT_MAX           6'h28
// Whole-frame lengths checked when select rises
`define CNT_OPCODE_ONLY   6'h08
`define CNT_STATUS_FRAME  6'h10
`define CNT_ADDR_FRAME    6'h20
// Bits in before the first output bit
`define HDR_SHORT         6'h08
`define HDR_ADDR          6'h20
`define HDR_DUMMY         6'h28
`define HDR_NEVER         6'h3F

// ==========================================================================
// Status register layout and reset values
`define SR_GUARD_POS      7
`define SR_BP_HI          4
`define SR_BP_LO          2
`define SR_GUARD_RESET    1'b0
`define SR_BP_RESET       3'h0

// ==========================================================================
// Timing
`define MCLK_MHZ          25
`define PROG_TIME_US      1200
`define SECTOR_TIME_US    75000
`define BLOCK_TIME_US     350000
`define CHIP_TIME_US      4000000
`define BUSY_W            27

`endif

// ===== flash_fe_pkg.sv
// Types shared by the serial flash front end.
// Assumes flash_fe_consts.svh is compiled alongside.
`default_nettype none

package flash_fe_pkg;

	// ======================================================================
	// Decoded command of the current frame
	typedef enum logic [4:0] {
		no_cmd,
		status_read_cmd,
		latch_set_cmd,
		latch_clr_cmd,
		status_write_cmd,
		page_program_cmd,
		sector_erase_cmd,
		block32_erase_cmd,
		block64_erase_cmd,
		chip_erase_cmd,
		read_cmd,
		fast_read_cmd,
		dual_read_cmd,
		deep_sleep_cmd,
		wake_id_cmd,
		mfr_id_cmd,
		read_identification_cmd,
		unique_id_cmd,
		unknown_cmd
	} cmd_t;

	// ======================================================================
	// Erase size handed to the array
	typedef enum logic [1:0] {
		erase_sector,
		erase_block32,
		erase_block64,
		erase_chip
	} erase_kind_t;

endpackage

`default_nettype wire

// ===== pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes every bit is independent; no bus coherence is promised.
`default_nettype none

module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta;

	// ======================================================================
	// First stage feeds only the second
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			meta <= '0;
			o_q  <= '0;
		end else begin
			meta <= i_d;
			o_q  <= meta;
		end
	end

endmodule // pin_sync

`default_nettype wire

// ===== flash_host_model.sv
// Host SPI master model: select, link clock and serial data out.
// Assumes the bench calls xfer and sets m3 for clock mode 3.
`default_nettype none

module flash_host_model (
	input  wire logic i_mclk,
	input  wire logic i_out_lane_high,
	input  wire logic i_lane_low,
	output logic      o_sclk,
	output logic      o_select_n,
	output logic      o_mosi,
	output logic      o_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic m3 = 1'b0;

	// Idle: deselected, clock low, driving data
	initial begin
		o_sclk = 1'b0;
		o_select_n = 1'b1;
		o_mosi = 1'b0;
		o_drive = 1'b1;
	end

	// Half link period; changes land just after a system edge
	task automatic half();
		repeat (4) @(posedge i_mclk);
		#1;
	endtask

	// ======================================================================
	// One frame: opcode first, MSB first; read bits taken on rises
	task automatic xfer(input logic [47:0] tx, input int hdr,
		input int ncyc, input bit dual, output logic [63:0] rx);
		rx = '0;
		o_sclk = m3;
		o_select_n = 1'b0;
		half();
		for (int i = 0; i < hdr + ncyc; i++) begin
			o_sclk = 1'b0;
			o_mosi = (i < 48) ? tx[47-i] : 1'b0;
			o_drive = !(dual && i >= hdr); // Let go for dual data
			half();
			o_sclk = 1'b1;
			if (i >= hdr)
				rx = dual ? {rx[61:0], i_out_lane_high, i_lane_low}
					: {rx[62:0], i_out_lane_high};
			half();
		end
		o_sclk = m3;
		o_select_n = 1'b1;
		o_drive = 1'b1;
		half();
		half();
	endtask
endmodule // flash_host_model

`default_nettype wire

// ===== serial_flash_spi_front_end_tb.sv
// Self-checking bench of the serial flash front end with a host model.
// Assumes the design files and flash_host_model are compiled first.
`default_nettype none

module serial_flash_spi_front_end_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_mclk = 1'b0, i_rst = 1'b1, i_protect_n = 1'b1;
	logic sclk, sel_n, mosi, hdrv, lo, lo_oe, hi, hi_oe, pstb, estb;
	logic busy, latch, sleep, lane0, lane1;
	logic [23:0] addr, pa_c;
	logic [7:0] arr, pd, pd_c;
	logic [63:0] rx;
	flash_fe_pkg::erase_kind_t ek, ek_c;
	int miscompares = 0, n_tests = 0, npg = 0, ner = 0, oe_cnt = 0;

	always #20 i_mclk = ~i_mclk;
	// Array stand-in answers at once; released lanes show the inverse
	assign arr = addr[7:0] ^ 8'h3C;
	assign lane0 = lo_oe ? lo : (hdrv ? mosi : ~mosi);
	assign lane1 = hi_oe ? hi : ~hi;

	// One-cycle strobes and lane drive are caught every edge
	always @(posedge i_mclk) begin
		if (pstb === 1'b1) begin
			npg++;
			pd_c = pd;
			pa_c = addr;
		end
		if (estb === 1'b1) begin
			ner++;
			ek_c = ek;
		end
		if (lo_oe === 1'b1 || hi_oe === 1'b1)
			oe_cnt++;
	end

	flash_host_model host_u (.i_mclk(i_mclk), .i_out_lane_high(lane1),
		.i_lane_low(lane0), .o_sclk(sclk), .o_select_n(sel_n),
		.o_mosi(mosi), .o_drive(hdrv));
	flash_spi_front_end #(.PROG_CYCLES(20), .SECTOR_CYCLES(40),
		.BLOCK_CYCLES(60), .CHIP_CYCLES(80)) dut_u (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_sclk(sclk), .i_select_n(sel_n),
		.i_bidir_lane_low(lane0), .i_protect_n(i_protect_n),
		.i_arr_data(arr), .o_bidir_lane_low(lo), .o_bidir_lane_low_oe(lo_oe),
		.o_out_lane_high(hi), .o_out_lane_high_oe(hi_oe), .o_arr_addr(addr),
		.o_prog_strobe(pstb), .o_prog_data(pd), .o_erase_strobe(estb),
		.o_erase_kind(ek), .o_busy(busy), .o_write_latch_flag(latch),
		.o_deep_sleep(sleep));

	// ======================================================================
	// Shared helpers
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [7:0] c);
		host_u.xfer({c, 40'h0}, 8, 0, 1'b0, rx);
	endtask
	task automatic st();
		host_u.xfer({8'h05, 40'h0}, 8, 8, 1'b0, rx);
	endtask
	// Bounded wait for busy to drop
	task automatic wait_idle(output int n);
		n = 0;
		while (busy !== 1'b0 && n < 1000) begin
			@(posedge i_mclk);
			n++;
		end
		#1;
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ======================================================================
	// Scenarios
	task automatic t_status();
		op(8'h06);
		check(latch, 1'b1);
		st();
		check(rx, 64'h02);
		host_u.xfer({16'h019C, 32'h0}, 16, 0, 1'b0, rx);
		st();
		check(rx, 64'h9C);
		i_protect_n = 1'b0;
		op(8'h06);
		host_u.xfer({16'h0100, 32'h0}, 16, 0, 1'b0, rx);
		st();
		check(rx[7:2], 6'h27);
		i_protect_n = 1'b1;
		op(8'h06);
		host_u.xfer({16'h0100, 32'h0}, 16, 0, 1'b0, rx);
		op(8'h04);
		st();
		check(rx, 64'h00);
	endtask
	task automatic t_read();
		for (int m = 0; m < 2; m++) begin
			host_u.m3 = m[0];
			host_u.xfer({32'h030012FF, 16'h0}, 32, 16, 1'b0, rx);
			check(rx, 64'hC33C);
		end
		host_u.m3 = 1'b0;
		host_u.xfer({32'h0B000010, 16'h0}, 40, 16, 1'b0, rx);
		check(rx, 64'h2C2D);
		host_u.xfer({32'h3B000040, 16'h0}, 40, 8, 1'b1, rx);
		check(rx, 64'h7C7D);
	endtask
	task automatic t_ids();
		int k;
		host_u.xfer({8'h9F, 40'h0}, 8, 24, 1'b0, rx);
		check(rx, 64'h5A4014);
		host_u.xfer({8'h90, 40'h0}, 32, 16, 1'b0, rx);
		check(rx, 64'h5A13);
		host_u.xfer({8'h4B, 40'h0}, 40, 64, 1'b0, rx);
		check(rx, 64'h0123456789ABCDEF);
		op(8'hB9);
		check(sleep, 1'b1);
		k = oe_cnt;
		host_u.xfer({8'h9F, 40'h0}, 8, 24, 1'b0, rx);
		check(oe_cnt - k, 0);
		host_u.xfer({8'hAB, 40'h0}, 32, 8, 1'b0, rx);
		check({sleep, rx[7:0]}, 9'h013);
		k = oe_cnt;
		host_u.xfer({8'hFF, 40'h0}, 8, 16, 1'b0, rx);
		check(oe_cnt - k, 0);
	endtask
	// Two bytes from the page end: the second wraps to the page start
	task automatic t_prog();
		int n, p;
		p = npg;
		op(8'h06);
		host_u.xfer({32'h02000AFF, 16'hA55A}, 48, 0, 1'b0, rx);
		check(npg - p, 2);
		check({pd_c, pa_c}, {8'h5A, 24'h000A00});
		check(busy, 1'b1);
		wait_idle(n);
		check(n > 0 && n < 20, 1'b1);
		check(latch, 1'b0);
	endtask
	task automatic t_erase();
		logic [7:0] ops [5] = '{8'hC7, 8'h60, 8'h20, 8'h52, 8'hD8};
		int n, e;
		for (int i = 0; i < 5; i++) begin
			e = ner;
			op(8'h06);
			host_u.xfer({ops[i], 40'h0}, i < 2 ? 8 : 32, 0, 1'b0, rx);
			check(ner - e, 1);
			check(ek_c, i < 2 ? 3 : i - 2);
			wait_idle(n);
			check(n > 0 && n < 100, 1'b1);
			check(latch, 1'b0);
		end
	endtask

	// Main sequence after three cycles of reset
	initial begin
		repeat (3) @(posedge i_mclk);
		#1 i_rst = 1'b0;
		check({lo_oe, hi_oe, busy, latch, sleep}, 5'h0);
		repeat (8) @(posedge i_mclk);
		t_status();
		t_read();
		t_ids();
		t_prog();
		t_erase();
		summarize();
	end
	// Watchdog: all frames need well under a millisecond
	initial begin
		#2000000;
		miscompares++;
		summarize();
	end
endmodule // serial_flash_spi_front_end_tb

`default_nettype wire
